/* core/ips_defines.vh */
/*
 * Constants of the interrupt priority and status block: APB register
 * offsets, field positions, reset values and event bit positions.
 * Assumes it is included by bare name from the core files.
 */
`ifndef IPS_DEFINES_VH
`define IPS_DEFINES_VH

// register byte offsets
`define IPS_OFF_VD_PRIO      12'h000
`define IPS_OFF_MU_PRIO      12'h004
`define IPS_OFF_CTL_STAT     12'h008
`define IPS_OFF_EV_STAT      12'h00C
`define IPS_OFF_EV_MASK      12'h010

// priority field positions
`define IPS_VD_PRIO_LSB      0
`define IPS_MU_PRIO_LSB      4
`define IPS_PRIO_W           3
`define IPS_PRIO_RESET       3'h4
`define IPS_PRIO_OFF         3'h0

// control and status register fields
`define IPS_PEND_BIT         15
`define IPS_HOLD_BIT         13
`define IPS_LEVEL_LSB        8
`define IPS_LEVEL_W          4
`define IPS_VEC_LSB          0
`define IPS_VEC_W            7
`define IPS_HOLD_RESET       1'h0
`define IPS_LEVEL_RESET      4'h0
`define IPS_VEC_RESET        7'h00

// event status and mask bits
`define IPS_EV_W             2
`define IPS_EV_NEW_PEND      0
`define IPS_EV_ACK           1
`define IPS_EV_RESET         2'h0

`endif

/* core/ips_arbiter.v */
/*
 * Combinational pick of the highest priority request among the
 * voltage-detect and measurement-unit sources.
 * Assumes requests and priority codes are stable in the pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module ips_arbiter #(
    parameter [6:0] VD_VECTOR = 7'h01,
    parameter [6:0] MU_VECTOR = 7'h02
) (
    // source side
    input  wire       vd_req,
    input  wire [2:0] vd_prio,
    input  wire       mu_req,
    input  wire [2:0] mu_prio,
    // winner
    output reg        win_valid,
    output reg        win_sel_mu,
    output reg  [2:0] win_prio,
    output reg  [6:0] win_vec
);

    // a source counts only with a nonzero priority code
    function live;
        input       req;
        input [2:0] prio;
        begin
            live = req & (prio != 3'h0);
        end
    endfunction

    always @* begin
        win_valid  = 1'b0;
        win_sel_mu = 1'b0;
        win_prio   = 3'h0;
        win_vec    = 7'h00;
        if (live(vd_req, vd_prio) &&
            (!live(mu_req, mu_prio) || vd_prio >= mu_prio)) begin
            win_valid = 1'b1;
            win_prio  = vd_prio;
            win_vec   = VD_VECTOR;
        end else if (live(mu_req, mu_prio)) begin
            win_valid  = 1'b1;
            win_sel_mu = 1'b1;
            win_prio   = mu_prio;
            win_vec    = MU_VECTOR;
        end
    end

endmodule

`default_nettype wire

/* core/ips_top.v */
/*
 * Interrupt priority and status block: two source priority registers,
 * the control and status register, a CPU request/acknowledge port and
 * an event interrupt, all behind an APB slave.
 * Assumes a single pclk domain and source requests synchronous to it.
 */
// Operation
// - voltage-detect priority field bits 2..0
// - priority zero disables the source
// - voltage-detect bits 15..3 read zero
// - measurement-unit field bits 6..4, rest zero
// - bit 15 flags unacknowledged pending request
// - hold set shows highest pending vector
// - hold clear shows last acknowledged vector
// - level field is new CPU level
`timescale 1ns/1ps
`default_nettype none
`include "ips_defines.vh"

module ips_top #(
    parameter [6:0] VD_VECTOR = 7'h01,
    parameter [6:0] MU_VECTOR = 7'h02
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    // interrupt sources
    input  wire        vd_src_req,
    input  wire        mu_src_req,
    // cpu port
    input  wire [3:0]  cpu_level,
    input  wire        cpu_ack,
    output reg         cpu_req_q,
    output reg  [3:0]  cpu_req_level_q,
    output reg  [6:0]  cpu_req_vec_q,
    // event interrupt
    output reg         irq_q
);

    // software state
    reg  [2:0]  voltage_detect_prio_q;
    reg  [2:0]  measurement_unit_prio_q;
    reg         vector_hold_q;
    reg  [1:0]  ev_mask_q;
    reg  [1:0]  ev_stat_q;
    reg  [1:0]  ev_stat_d;

    // cpu facing state
    reg         vd_busy_q;
    reg         mu_busy_q;
    reg         pending_request_flag_q;
    reg  [3:0]  new_priority_level_q;
    reg  [6:0]  ack_vec_q;
    reg  [6:0]  vector_number_q;
    // which source the offered request belongs to
    reg         req_sel_mu_q;

    // read capture of event bits, so only reported bits get cleared
    reg  [1:0]  ev_seen_q;

    wire        win_valid;
    wire        win_sel_mu;
    wire [2:0]  win_prio;
    wire [6:0]  win_vec;

    wire        setup;
    wire        access;
    wire        wr_acc;
    wire        rd_acc;
    wire        ack_take;
    wire [3:0]  win_level;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    wire [1:0]  ev_new;

    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready_q;
    assign wr_acc   = access & pwrite;
    assign rd_acc   = access & ~pwrite;
    assign win_level = {1'b0, win_prio};

    // sources already acknowledged stay out until their request drops
    ips_arbiter #(
        .VD_VECTOR (VD_VECTOR),
        .MU_VECTOR (MU_VECTOR)
    ) u_arb (
        .vd_req     (vd_src_req & ~vd_busy_q),
        .vd_prio    (voltage_detect_prio_q),
        .mu_req     (mu_src_req & ~mu_busy_q),
        .mu_prio    (measurement_unit_prio_q),
        .win_valid  (win_valid),
        .win_sel_mu (win_sel_mu),
        .win_prio   (win_prio),
        .win_vec    (win_vec)
    );

    // ack only counts while a request is actually offered
    assign ack_take = cpu_ack & cpu_req_q;

    // register map decode
    function [11:0] word_addr;
        input [11:0] a;
        begin
            word_addr = {a[11:2], 2'h0};
        end
    endfunction

    // a read of the event status word, in either apb phase
    function ev_stat_read;
        input        wr;
        input [11:0] a;
        begin
            ev_stat_read = !wr && (word_addr(a) == `IPS_OFF_EV_STAT);
        end
    endfunction

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (word_addr(paddr))
            `IPS_OFF_VD_PRIO: begin
                rd_mux[`IPS_VD_PRIO_LSB +: `IPS_PRIO_W] =
                    voltage_detect_prio_q;
            end
            `IPS_OFF_MU_PRIO: begin
                rd_mux[`IPS_MU_PRIO_LSB +: `IPS_PRIO_W] =
                    measurement_unit_prio_q;
            end
            `IPS_OFF_CTL_STAT: begin
                rd_mux[`IPS_PEND_BIT] = pending_request_flag_q;
                rd_mux[`IPS_HOLD_BIT] = vector_hold_q;
                rd_mux[`IPS_LEVEL_LSB +: `IPS_LEVEL_W] =
                    new_priority_level_q;
                rd_mux[`IPS_VEC_LSB +: `IPS_VEC_W] = vector_number_q;
            end
            `IPS_OFF_EV_STAT: begin
                rd_mux[`IPS_EV_W-1:0] = ev_stat_q;
            end
            `IPS_OFF_EV_MASK: begin
                rd_mux[`IPS_EV_W-1:0] = ev_mask_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // apb answer: zero wait state, data latched in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            ev_seen_q <= `IPS_EV_RESET;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= ~rd_hit;
                if (ev_stat_read(pwrite, paddr)) begin
                    ev_seen_q <= ev_stat_q;
                end else begin
                    ev_seen_q <= `IPS_EV_RESET;
                end
            end else if (access) begin
                // error only stands with the access phase
                pslverr_q <= 1'b0;
            end
        end
    end

    // software writable fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_detect_prio_q   <= `IPS_PRIO_RESET;
            measurement_unit_prio_q <= `IPS_PRIO_RESET;
            vector_hold_q           <= `IPS_HOLD_RESET;
            ev_mask_q               <= `IPS_EV_RESET;
        end else if (wr_acc) begin
            case (word_addr(paddr))
                `IPS_OFF_VD_PRIO: begin
                    voltage_detect_prio_q <=
                        pwdata[`IPS_VD_PRIO_LSB +: `IPS_PRIO_W];
                end
                `IPS_OFF_MU_PRIO: begin
                    measurement_unit_prio_q <=
                        pwdata[`IPS_MU_PRIO_LSB +: `IPS_PRIO_W];
                end
                `IPS_OFF_CTL_STAT: begin
                    vector_hold_q <= pwdata[`IPS_HOLD_BIT];
                end
                `IPS_OFF_EV_MASK: begin
                    ev_mask_q <= pwdata[`IPS_EV_W-1:0];
                end
                default: begin
                    // event status is read-only, writes there drop
                    vector_hold_q <= vector_hold_q;
                end
            endcase
        end
    end

    // in-service tracking per source
    // keyed on the select, so equal vector numbers stay apart
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vd_busy_q <= 1'b0;
            mu_busy_q <= 1'b0;
        end else begin
            if (!vd_src_req) begin
                vd_busy_q <= 1'b0;
            end else if (ack_take && !req_sel_mu_q) begin
                vd_busy_q <= 1'b1;
            end
            if (!mu_src_req) begin
                mu_busy_q <= 1'b0;
            end else if (ack_take && req_sel_mu_q) begin
                mu_busy_q <= 1'b1;
            end
        end
    end

    // cpu request port and status fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // nothing offered or acknowledged yet
            cpu_req_q              <= 1'b0;
            cpu_req_level_q        <= `IPS_LEVEL_RESET;
            cpu_req_vec_q          <= `IPS_VEC_RESET;
            pending_request_flag_q <= 1'b0;
            new_priority_level_q   <= `IPS_LEVEL_RESET;
            ack_vec_q              <= `IPS_VEC_RESET;
            vector_number_q        <= `IPS_VEC_RESET;
            req_sel_mu_q           <= 1'b0;
        end else begin
            // an ack drops the offer; the next winner waits a cycle
            // only enabled winners reach the cpu
            cpu_req_q       <= win_valid & (win_level > cpu_level) &
                               ~ack_take;
            cpu_req_level_q <= win_level;
            cpu_req_vec_q   <= win_vec;
            req_sel_mu_q    <= win_sel_mu;
            // counted at any cpu level, so blocked requests show
            // unacknowledged request pending
            pending_request_flag_q <= win_valid & ~ack_take;
            if (ack_take) begin
                new_priority_level_q <= cpu_req_level_q;
                ack_vec_q            <= cpu_req_vec_q;
            end
            if (vector_hold_q) begin
                vector_number_q <= win_valid ? win_vec : `IPS_VEC_RESET;
            end else begin
                // hold clear falls back to the captured ack vector
                // last acknowledged vector
                vector_number_q <= ack_take ? cpu_req_vec_q : ack_vec_q;
            end
        end
    end

    // sticky events: a set in the clearing cycle wins
    assign ev_new[`IPS_EV_NEW_PEND] = win_valid & ~pending_request_flag_q
                                      & ~ack_take;
    assign ev_new[`IPS_EV_ACK]      = ack_take;

    always @* begin
        ev_stat_d = ev_stat_q;
        // bits set after the read was answered survive the clear
        if (rd_acc && ev_stat_read(pwrite, paddr)) begin
            ev_stat_d = ev_stat_q & ~ev_seen_q;
        end
        ev_stat_d = ev_stat_d | ev_new;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_q <= `IPS_EV_RESET;
            irq_q     <= 1'b0;
        end else begin
            ev_stat_q <= ev_stat_d;
            irq_q     <= |(ev_stat_d & ev_mask_q);
        end
    end

endmodule

`default_nettype wire

/* bench/ips_props.sv */
/* checker for ips_top: apb timing and cpu request relations
   assumes binding from the bench top, one pclk domain */
`timescale 1ns/1ps
`default_nettype none
module ips_props #(
    parameter [6:0] VD_VECTOR = 7'h01,
    parameter [6:0] MU_VECTOR = 7'h02
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    // sources and cpu
    input wire logic        vd_src_req,
    input wire logic        mu_src_req,
    input wire logic [3:0]  cpu_level,
    input wire logic        cpu_ack,
    input wire logic        cpu_req_q,
    input wire logic [3:0]  cpu_req_level_q,
    input wire logic [6:0]  cpu_req_vec_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_zero_wait: assert property (psel && !penable |=> pready_q)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (pready_q |=> !pready_q)
        else $error("ready held too long");
    chk_err_reads_zero: assert property (
        pslverr_q |-> pready_q && prdata_q == 0)
        else $error("error response not clean");
    chk_ack_drops_req: assert property (cpu_req_q && cpu_ack |=> !cpu_req_q)
        else $error("request stayed after ack");
    chk_prio_nonzero: assert property (
        cpu_req_q |-> cpu_req_level_q inside {[1:7]})
        else $error("disabled or bad priority offered");
    chk_above_level: assert property (
        cpu_req_q |-> cpu_req_level_q > $past(cpu_level))
        else $error("offered at or below cpu level");
    chk_vector_known: assert property (
        cpu_req_q |-> cpu_req_vec_q == VD_VECTOR || cpu_req_vec_q == MU_VECTOR)
        else $error("offered vector unknown");
    chk_req_needs_src: assert property (
        (!vd_src_req && !mu_src_req) [*2] |-> !cpu_req_q)
        else $error("request without source");
    cov_ack: cover property (cpu_req_q && cpu_ack);
    cov_err: cover property (pslverr_q);
    cov_held: cover property ((vd_src_req && !cpu_req_q) [*4]);
endmodule
`default_nettype wire

/* bench/ips_cpu_model.sv */
/* cpu core model: shows a level, acks offered requests after a delay
   assumes the block counts an ack only while it requests */
`timescale 1ns/1ps
`default_nettype none
module ips_cpu_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench control
    input  wire logic [3:0] level_set,
    input  wire logic [3:0] ack_delay,
    // block side
    input  wire logic       cpu_req_q,
    output var logic [3:0]  cpu_level,
    output var logic        cpu_ack,
    output var int          n_acks
);
    int wait_cnt;
    assign cpu_level = level_set;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            wait_cnt <= 0;
            n_acks <= 0;
        end else begin
            cpu_ack <= 1'b0;
            // never ack twice: request drops one edge after our pulse
            if (cpu_req_q && !cpu_ack) begin
                if (wait_cnt >= ack_delay) begin
                    cpu_ack <= 1'b1;
                    n_acks <= n_acks + 1;
                    wait_cnt <= 0;
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end else begin
                wait_cnt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/ips_bench.sv */
/* self-checking bench for ips_top with apb master and cpu model
   assumes the checker is bound here, 200 MHz pclk */
`timescale 1ns/1ps
`default_nettype none
module ips_bench;
    logic        pclk, presetn, psel, penable, pwrite, vd_src_req, mu_src_req;
    logic        pready_q, pslverr_q, cpu_ack, cpu_req_q, irq_q, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_q, rd, r;
    logic [3:0]  cpu_level, cpu_req_level_q, level_set, ack_delay;
    logic [6:0]  cpu_req_vec_q;
    int          n_acks, n_errors, samples_checked, seed, i;
    int          exp_v, exp_q [$];
    logic [31:0] rst_exp [5] = '{32'h4, 32'h40, 32'h0, 32'h0, 32'h0};

    ips_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .vd_src_req(vd_src_req), .mu_src_req(mu_src_req),
        .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_req_q(cpu_req_q),
        .cpu_req_level_q(cpu_req_level_q), .cpu_req_vec_q(cpu_req_vec_q),
        .irq_q(irq_q));
    ips_cpu_model cpu (.pclk(pclk), .presetn(presetn), .level_set(level_set),
        .ack_delay(ack_delay), .cpu_req_q(cpu_req_q), .cpu_level(cpu_level),
        .cpu_ack(cpu_ack), .n_acks(n_acks));

    always #2.5 pclk = ~pclk;

    // model: each taken offer, as level*128+vector, in expected order
    always @(posedge pclk) begin
        if (presetn && cpu_ack && cpu_req_q) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
            chk({21'h0, cpu_req_level_q, cpu_req_vec_q}, 32'(exp_v));
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] stat(bit p, bit h, int l, logic [6:0] v);
        return (32'(p) << 15) | (32'(h) << 13) | (32'(l) << 8) | 32'(v);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready_q === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            finish_test();
        end
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_acks(input int n);
        for (i = 0; i < 50 && n_acks < n; i++) @(posedge pclk);
        if (n_acks < n) begin
            n_errors++;
            finish_test();
        end
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, vd_src_req, mu_src_req} = 0;
        {paddr, pwdata, level_set, ack_delay} = 0;
        seed = 63455;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 12'(k * 4), 32'h0);
            chk(rd, rst_exp[k]);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        repeat (6) begin
            r = xs();
            apb(1'b1, 12'h000, r);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, {29'h0, r[2:0]});
            apb(1'b1, 12'h004, r);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, {25'h0, r[6:4], 4'h0});
        end
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h010, 32'h3);
        vd_src_req <= 1'b1;
        tick(6);
        chk(cpu_req_q, 0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 0);
        // mu at priority 5 is the first offer taken
        exp_q.push_back(5 * 128 + 2);
        mu_src_req <= 1'b1;
        wait_acks(1);
        tick(2);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, stat(0, 0, 5, 7'h02));
        chk(irq_q, 1);
        apb(1'b1, 12'h010, 32'h0);
        tick(2);
        chk(irq_q, 0);
        apb(1'b1, 12'h010, 32'h3);
        tick(2);
        chk(irq_q, 1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 3);
        tick(2);
        chk(irq_q, 0);
        // cpu level 7 keeps a priority 7 request pending, not offered
        mu_src_req <= 1'b0;
        level_set <= 4'h7;
        ack_delay <= 4'h3;
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b1, 12'h008, 32'h2000);
        tick(4);
        chk(cpu_req_q, 0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, stat(1, 1, 5, 7'h01));
        // vd at priority 7 once the cpu level drops
        exp_q.push_back(7 * 128 + 1);
        level_set <= 4'h0;
        wait_acks(2);
        tick(2);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, stat(0, 1, 7, 7'h00));
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, stat(0, 0, 7, 7'h01));
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule

bind ips_top ips_props #(.VD_VECTOR(VD_VECTOR), .MU_VECTOR(MU_VECTOR))
    u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .vd_src_req(vd_src_req), .mu_src_req(mu_src_req),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_req_q(cpu_req_q),
    .cpu_req_level_q(cpu_req_level_q), .cpu_req_vec_q(cpu_req_vec_q));
`default_nettype wire
